// ==== secs_pkg.sv ====
// constants and types of the spi eeprom command and status block
package secs_pkg;

    // opcodes, taken msb first on the first eight clocks
    localparam logic [7:0] OP_SET_WE  = 8'h06;
    localparam logic [7:0] OP_CLR_WE  = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_MEM_RD  = 8'h03;
    localparam logic [7:0] OP_MEM_WR  = 8'h02;

    // completed byte counts of a frame and the index of the last bit of a byte
    localparam logic [2:0] BYTES_OPCODE     = 3'h1;
    localparam logic [2:0] BYTES_STAT_WR    = 3'h2;
    localparam logic [2:0] BYTES_ADDR_END   = 3'h3;
    localparam logic [2:0] BYTES_MEM_WR_MIN = 3'h4;
    localparam logic [2:0] BYTES_MAX        = 3'h7;
    localparam logic [2:0] BIT_LAST         = 3'h7;

    // page buffer
    localparam int PAGE_W     = 5;
    localparam int PAGE_BYTES = 32;

    // status byte positions inside the written data byte
    localparam int SB_SWD    = 7;
    localparam int SB_BP_HI  = 3;
    localparam int SB_BP_LO  = 2;

    // reset values
    localparam logic [2:0] NV_RESET    = 3'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // internal write time
    localparam int WRITE_TIME_US = 5000;
    localparam int CLK_MHZ       = 10;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic       swd;
        logic [2:0] zero;
        logic [1:0] bp;
        logic       write_enable_latch;
        logic       write_in_progress;
    } secs_status_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PROG = 2'b10
    } secs_state_t;

endpackage : secs_pkg

// ==== secs_top.sv ====
// spi eeprom command decoder, status register and array
// Summary of operation
// [RULE1] after chip select falls, the first eight clocks carry the opcode msb first
// [RULE2] an unknown opcode deselects the device until chip select rises
// [RULE3] opcodes 06 set, 04 clear write enable, 05 status read, 01 status write
// [RULE4] opcode 03 reads memory, opcode 02 writes memory
// [RULE5] address high byte clocks 9-16, low byte 17-24, data from 25
// [RULE6] address bits above the array size are ignored
// [RULE7] disable bit set with protect pin low locks status writes
// [RULE8] the two block protect bits rewrite by status write unless locked
// [RULE9] only set-write-enable sets the latch; cleared latch rejects writes
// [RULE10] latch clears on reset, clear command, and end of internal write
// [RULE11] bit 0 reads 1 during an internal write, else 0
// [RULE12] set-write-enable acts only when select rises after exactly 8 clocks
// [RULE13] clear-write-enable acts only when select rises after exactly 8 clocks
// [RULE14] status read repeats the status byte while clocks continue
// [RULE15] status reads work during a write and show live latch and busy
// [RULE16] old protect values show until the status write cycle ends
// [RULE17] status write changes bits 7,3,2 only; bits 6-4 read zero
// [RULE18] select rising after the data byte starts the timed write
// [RULE19] status write acts only when select rises after exactly 16 clocks
// [RULE20] hold tri-states the output and freezes all command state
// [RULE21] a fresh model reads ff everywhere with protect bits zero
// [RULE22] inputs taken on rising clock, output changes on falling clock
// [RULE23] sequential read increments the address and wraps at the top
// [RULE24] write time is a parameter; no write starts while busy
// [RULE25] chip select high restarts bit counting and decoding
`timescale 1ns/1ps

module secs_sync3 #(
    parameter logic RST_VAL = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // pin in, filtered level and its rising pulse out
    input  wire logic d,
    output logic      lvl,
    output logic      rise
);
    logic q1_r;
    logic q2_r;
    logic q3_r;
    wire  agree = (q2_r == q3_r);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q1_r <= RST_VAL;
            q2_r <= RST_VAL;
            q3_r <= RST_VAL;
        end else begin
            q1_r <= d;
            q2_r <= q1_r;
            q3_r <= q2_r;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            lvl  <= RST_VAL;
            rise <= 1'b0;
        end else begin
            rise <= agree & q3_r & ~lvl;
            if (agree) begin
                lvl <= q3_r;
            end
        end
    end
endmodule : secs_sync3

module secs_top #(
    parameter int ADDR_W       = 13,
    parameter int WRITE_CYCLES = secs_pkg::WRITE_CYCLES
) (
    // system
    input  wire logic clk,
    input  wire logic rstn,
    // serial link
    input  wire logic spi_sck,
    input  wire logic spi_cs_n,
    input  wire logic spi_si,
    input  wire logic spi_hold_n,
    output logic      spi_so,
    output logic      spi_so_oe,
    // write protect pin
    input  wire logic wp_n
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam int PW    = secs_pkg::PAGE_W;
    localparam int PB    = secs_pkg::PAGE_BYTES;

    if (ADDR_W < PW + 2 || ADDR_W > 16) begin : g_bad_addr
        $error("secs_top: ADDR_W out of range");
    end
    if (WRITE_CYCLES < PB + 1) begin : g_bad_time
        $error("secs_top: WRITE_CYCLES too small for page copy");
    end

    // array, erased at start
    logic [7:0] mem [0:DEPTH-1];
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            mem[i] = secs_pkg::ERASED_BYTE; // [RULE21]
        end
    end

    // clock domain of the link
    logic                       start_r;
    logic                       tgl_r = 1'b0;
    logic [2:0]                 bitc_r;
    logic [2:0]                 bytec_r;
    logic [6:0]                 sh_r;
    logic [7:0]                 op_r;
    logic [7:0]                 arg_r;
    logic [15:0]                addr_r;
    logic                       inv_r;
    logic [PB-1:0]              pval_r;
    logic [7:0]                 pbuf [0:PB-1];
    secs_pkg::secs_status_t     stat_m_r;
    secs_pkg::secs_status_t     stat_s_r;
    secs_pkg::secs_status_t     stat_r;

    // frame start flag, set while deselected
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            start_r <= 1'b1; // [RULE25]
        end else if (spi_hold_n) begin
            start_r <= 1'b0;
        end
    end

    wire [2:0]  bit_base   = start_r ? 3'h0 : bitc_r; // [RULE25]
    wire [2:0]  byte_base  = start_r ? 3'h0 : bytec_r;
    wire        byte_done  = (bit_base == secs_pkg::BIT_LAST);
    wire [7:0]  rx_byte    = {sh_r, spi_si};
    wire        at_opcode  = byte_done & (byte_base == 3'h0);
    wire        at_addr_hi = byte_done & (byte_base == secs_pkg::BYTES_OPCODE);
    wire        at_addr_lo = byte_done & (byte_base == secs_pkg::BYTES_STAT_WR);
    wire        at_data    = byte_done & (byte_base >= secs_pkg::BYTES_ADDR_END);
    wire        op_known   = (rx_byte == secs_pkg::OP_SET_WE)  | // [RULE3]
                             (rx_byte == secs_pkg::OP_CLR_WE)  |
                             (rx_byte == secs_pkg::OP_STAT_RD) |
                             (rx_byte == secs_pkg::OP_STAT_WR) |
                             (rx_byte == secs_pkg::OP_MEM_RD)  | // [RULE4]
                             (rx_byte == secs_pkg::OP_MEM_WR);
    wire        rd_busy    = (rx_byte == secs_pkg::OP_MEM_RD) & stat_s_r.write_in_progress;
    wire        wr_data    = at_data & ~inv_r & ~stat_s_r.write_in_progress &
                             (op_r == secs_pkg::OP_MEM_WR); // [RULE24]
    wire        rd_data    = at_data & ~inv_r & (op_r == secs_pkg::OP_MEM_RD);

    wire [2:0]  bitc_nxt   = bit_base + 3'h1;
    wire [2:0]  bytec_nxt  = (byte_done && byte_base != secs_pkg::BYTES_MAX) ?
                             byte_base + 3'h1 : byte_base;
    wire        inv_nxt    = start_r ? 1'b0 :
                             at_opcode ? (~op_known | rd_busy) : inv_r; // [RULE2]
    wire [4:0]  pg_idx     = addr_r[PW-1:0];
    wire [4:0]  pg_inc     = pg_idx + 5'h01;
    wire [15:0] addr_nxt   = at_addr_hi ? {rx_byte, addr_r[7:0]} :   // [RULE5]
                             at_addr_lo ? {addr_r[15:8], rx_byte} :
                             rd_data    ? addr_r + 16'h0001 :         // [RULE23]
                             wr_data    ? {addr_r[15:PW], pg_inc} : addr_r;
    wire [PB-1:0] pval_nxt = (start_r ? {PB{1'b0}} : pval_r) |
                             (wr_data ? ({{(PB-1){1'b0}}, 1'b1} << pg_idx) : {PB{1'b0}});

    // input sampling on the rising edge, frozen while held
    always_ff @(posedge spi_sck) begin
        if (spi_hold_n) begin // [RULE20]
            bitc_r  <= bitc_nxt; // [RULE22]
            bytec_r <= bytec_nxt;
            sh_r    <= rx_byte[6:0];
            inv_r   <= inv_nxt;
            addr_r  <= addr_nxt;
            pval_r  <= pval_nxt;
        end
    end

    always_ff @(posedge spi_sck) begin
        if (spi_hold_n && start_r) begin
            tgl_r <= ~tgl_r;
        end
        if (spi_hold_n && at_opcode) begin
            op_r <= rx_byte; // [RULE1]
        end
        if (spi_hold_n && at_addr_hi) begin
            arg_r <= rx_byte;
        end
    end

    always_ff @(posedge spi_sck) begin
        if (spi_hold_n && wr_data) begin
            pbuf[pg_idx] <= rx_byte;
        end
    end

    // status byte brought into the link domain
    always_ff @(posedge spi_sck) begin
        stat_m_r <= stat_r;
        stat_s_r <= stat_m_r;
    end

    wire       rd_stat  = (op_r == secs_pkg::OP_STAT_RD) & (bytec_r >= secs_pkg::BYTES_OPCODE);
    wire       rd_mem   = (op_r == secs_pkg::OP_MEM_RD) & (bytec_r >= secs_pkg::BYTES_ADDR_END);
    wire       reading  = ~start_r & ~inv_r & (rd_stat | rd_mem);
    wire [7:0] mem_byte = mem[addr_r[ADDR_W-1:0]]; // [RULE6]
    wire [7:0] out_byte = (op_r == secs_pkg::OP_STAT_RD) ? stat_s_r : mem_byte; // [RULE14]

    // output shifting on the falling edge
    always_ff @(negedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            spi_so    <= 1'b1;
            spi_so_oe <= 1'b0;
        end else begin
            spi_so_oe <= reading & spi_hold_n; // [RULE20]
            if (spi_hold_n) begin
                spi_so <= out_byte[~bitc_r]; // [RULE22]
            end
        end
    end

    // system clock domain
    logic                    cs_lvl;
    logic                    cs_rise;
    logic                    wp_lvl;
    logic                    seen_r;
    logic                    wel_r;
    logic [2:0]              nv_r;
    logic [2:0]              new_r;
    logic                    mem_wr_r;
    logic [CNT_W-1:0]        tmr_r;
    secs_pkg::secs_state_t   st_r;
    secs_pkg::secs_state_t   st_nxt;

    secs_sync3 #(.RST_VAL(1'b1)) u_cs_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (spi_cs_n),
        .lvl  (cs_lvl),
        .rise (cs_rise)
    );

    secs_sync3 #(.RST_VAL(1'b1)) u_wp_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    (wp_n),
        .lvl  (wp_lvl),
        .rise ()
    );

    // frame snapshot is stable: the link clock idles while deselected
    wire       write_in_progress      = (st_r == secs_pkg::ST_PROG); // [RULE11]
    wire       clocked  = (tgl_r != seen_r);
    wire       fr_ok    = cs_rise & cs_lvl & clocked & ~inv_r & (bitc_r == 3'h0);
    wire       do_set   = fr_ok & (op_r == secs_pkg::OP_SET_WE) &
                          (bytec_r == secs_pkg::BYTES_OPCODE); // [RULE12]
    wire       do_clr   = fr_ok & (op_r == secs_pkg::OP_CLR_WE) &
                          (bytec_r == secs_pkg::BYTES_OPCODE); // [RULE13]
    wire       hw_prot  = nv_r[2] & ~wp_lvl; // [RULE7]
    wire       do_swr   = fr_ok & (op_r == secs_pkg::OP_STAT_WR) &
                          (bytec_r == secs_pkg::BYTES_STAT_WR) & // [RULE19]
                          wel_r & ~write_in_progress & ~hw_prot; // [RULE9]
    wire [1:0] quarter  = addr_r[ADDR_W-1 -: 2];
    wire [1:0] bp       = nv_r[1:0];
    wire       blk_prot = (bp == 2'h3) | ((bp == 2'h2) & quarter[1]) | // [RULE8]
                          ((bp == 2'h1) & (quarter == 2'h3));
    wire       do_mwr   = fr_ok & (op_r == secs_pkg::OP_MEM_WR) &
                          (bytec_r >= secs_pkg::BYTES_MEM_WR_MIN) &
                          wel_r & ~write_in_progress & ~blk_prot & (|pval_r); // [RULE24]
    wire       start_wr = do_swr | do_mwr; // [RULE18]
    wire       done     = write_in_progress & (tmr_r == CNT_W'(WRITE_CYCLES - 1));

    always_comb begin
        case (st_r)
            secs_pkg::ST_IDLE: st_nxt = start_wr ? secs_pkg::ST_PROG : secs_pkg::ST_IDLE;
            secs_pkg::ST_PROG: st_nxt = done ? secs_pkg::ST_IDLE : secs_pkg::ST_PROG;
            default:           st_nxt = secs_pkg::ST_IDLE;
        endcase
    end

    wire             wel_nxt  = do_set ? 1'b1 : ((do_clr | done) ? 1'b0 : wel_r); // [RULE10]
    wire [2:0]       nv_nxt   = (done & ~mem_wr_r) ? new_r : nv_r; // [RULE16]
    wire [2:0]       new_nxt  = do_swr ? {arg_r[secs_pkg::SB_SWD], arg_r[secs_pkg::SB_BP_HI],
                                          arg_r[secs_pkg::SB_BP_LO]} : new_r; // [RULE17]
    wire             mwr_nxt  = start_wr ? do_mwr : mem_wr_r;
    wire [CNT_W-1:0] tmr_nxt  = write_in_progress ? tmr_r + CNT_W'(1) : {CNT_W{1'b0}};
    wire             seen_nxt = cs_rise ? tgl_r : seen_r;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r     <= secs_pkg::ST_IDLE;
            tmr_r    <= {CNT_W{1'b0}};
            mem_wr_r <= 1'b0;
            seen_r   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            tmr_r    <= tmr_nxt;
            mem_wr_r <= mwr_nxt;
            seen_r   <= seen_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wel_r <= 1'b0; // [RULE10]
            nv_r  <= secs_pkg::NV_RESET; // [RULE21]
            new_r <= secs_pkg::NV_RESET;
        end else begin
            wel_r <= wel_nxt;
            nv_r  <= nv_nxt;
            new_r <= new_nxt;
        end
    end

    // live status for reads, also during a write
    always_comb begin
        stat_r      = '0;
        stat_r.swd  = nv_r[2];
        stat_r.bp   = nv_r[1:0];
        stat_r.write_enable_latch  = wel_r; // [RULE15]
        stat_r.write_in_progress  = write_in_progress; // [RULE11]
    end

    // page copy into the array during the timed write
    wire [PW-1:0]     cp_idx  = tmr_r[PW-1:0];
    wire              copy_en = write_in_progress & mem_wr_r & (tmr_r < CNT_W'(PB)) & pval_r[cp_idx];
    wire [ADDR_W-1:0] cp_addr = {addr_r[ADDR_W-1:PW], cp_idx};

    always @(posedge clk) begin
        if (copy_en) begin
            mem[cp_addr] <= pbuf[cp_idx];
        end
    end

endmodule : secs_top

// ==== secs_top_assertions.sv ====
// assertion checker for the spi eeprom command and status block
`timescale 1ns/1ps
module secs_top_assertions (
    // system
    input wire logic clk,
    input wire logic rstn,
    // serial link
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic spi_hold_n,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    // protect pin
    input wire logic wp_n
);
    logic [7:0] cnt_r;
    logic [7:0] op_r;

    // clocks and opcode bits of this frame, frozen during hold
    always_ff @(posedge spi_sck or posedge spi_cs_n) begin
        if (spi_cs_n) begin
            cnt_r <= 8'h00;
            op_r  <= 8'h00;
        end else if (spi_hold_n) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r < 8'h08) begin
                op_r <= {op_r[6:0], spi_si};
            end
        end
    end

    a_oe_desel: assert property (@(posedge clk) disable iff (!rstn)
        spi_cs_n |-> !spi_so_oe) else $error("output enabled while deselected");
    a_so_desel: assert property (@(posedge clk) disable iff (!rstn)
        spi_cs_n |-> spi_so) else $error("output not high while deselected");
    a_oe_hold: assert property (@(negedge spi_sck) disable iff (spi_cs_n)
        !spi_hold_n |=> !spi_so_oe) else $error("output enabled during hold");
    a_oe_opcode: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
        cnt_r < 8'h08 |-> !spi_so_oe) else $error("output during opcode");
    a_stat_oe: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
        cnt_r == 8'h08 && op_r == secs_pkg::OP_STAT_RD |-> spi_so_oe)
        else $error("status byte not driven after opcode");
    a_stat_zero: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
        op_r == secs_pkg::OP_STAT_RD && cnt_r >= 8'h09 && spi_so_oe
        && cnt_r[2:0] inside {3'h1, 3'h2, 3'h3} |-> !spi_so)
        else $error("status bits six to four not zero");
    a_read_addr: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
        op_r == secs_pkg::OP_MEM_RD && cnt_r >= 8'h08 && cnt_r < 8'h18 |-> !spi_so_oe)
        else $error("output during address bytes");
    a_quiet_nonread: assert property (@(posedge spi_sck) disable iff (spi_cs_n)
        cnt_r >= 8'h08 && op_r != secs_pkg::OP_STAT_RD && op_r != secs_pkg::OP_MEM_RD
        |-> !spi_so_oe) else $error("output for a non-read opcode");

    c_stat_repeat: cover property (@(posedge spi_sck)
        op_r == secs_pkg::OP_STAT_RD && cnt_r == 8'h10);
    c_mem_data: cover property (@(posedge spi_sck)
        op_r == secs_pkg::OP_MEM_RD && cnt_r == 8'h18 && spi_so_oe);
    c_hold: cover property (@(negedge spi_sck) !spi_hold_n && !spi_cs_n);
endmodule : secs_top_assertions

// ==== secs_host.sv ====
// spi host model driving select, clock, data and hold
`timescale 1ns/1ps
module secs_host (
    // link outputs
    output logic      spi_sck,
    output logic      spi_cs_n,
    output logic      spi_si,
    output logic      spi_hold_n,
    // link input
    input  wire logic spi_so
);
    initial begin
        spi_sck    = 1'b0;
        spi_cs_n   = 1'b1;
        spi_si     = 1'b0;
        spi_hold_n = 1'b1;
    end

    // one frame of n clocks plus two held clocks at hold_at, msb first, mode 0, clock still outside frames
    task automatic xfer(input int n, input logic [39:0] d, input int hold_at,
                        output logic [39:0] q);
        q = '0;
        spi_cs_n = 1'b0;
        #15;
        for (int i = n - 1; i >= 0; i--) begin
            spi_si = d[i];
            #15 spi_sck = 1'b1;
            q = {q[38:0], spi_so};
            if (i == hold_at) begin
                #5 spi_hold_n = 1'b0;
                repeat (2) begin
                    #10 spi_sck = 1'b0;
                    spi_si = ~spi_si;
                    #15 spi_sck = 1'b1;
                end
                #5 spi_hold_n = 1'b1;
            end
            #15 spi_sck = 1'b0;
        end
        #15 spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        #800;
    endtask : xfer
endmodule : secs_host

// ==== secs_top_tb.sv ====
// self-checking bench for the spi eeprom command and status block
`timescale 1ns/1ps
module secs_top_tb;
    logic        clk       = 1'b0;
    logic        rstn      = 1'b0;
    logic        wp_n      = 1'b1;
    logic        spi_sck;
    logic        spi_cs_n;
    logic        spi_si;
    logic        spi_hold_n;
    logic        spi_so;
    logic        spi_so_oe;
    logic [39:0] q;
    int          bad_count = 0;
    int          checked   = 0;
    wire         so_pin    = spi_so_oe ? spi_so : 1'bz;

    always #50 clk = ~clk;

    secs_top #(.ADDR_W(13), .WRITE_CYCLES(64)) i_secs_top (
        .clk(clk), .rstn(rstn), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_hold_n(spi_hold_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n));

    secs_host i_secs_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
        .spi_hold_n(spi_hold_n), .spi_so(so_pin));

    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task end_sim;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task frame(input int n, input logic [39:0] d);
        i_secs_host.xfer(n, d, -1, q);
    endtask : frame

    task stat(input logic [7:0] exp, input int hold_at);
        i_secs_host.xfer(24, 40'h05_0000, hold_at, q);
        chk("status", q[15:0], {exp, exp});
    endtask : stat

    task t_fresh;
        stat(8'h00, -1);
        frame(32, 40'h03_0000_00);
        chk("fresh byte", {8'h00, q[7:0]}, 16'h00ff);
    endtask : t_fresh

    task t_latch;
        frame(9, 40'h00c);
        stat(8'h00, -1);
        frame(8, 40'h06);
        stat(8'h02, -1);
        frame(7, 40'h02);
        stat(8'h02, -1);
        frame(8, 40'h04);
        stat(8'h00, -1);
        frame(16, 40'h01ff);
        #8000;
        stat(8'h00, -1);
    endtask : t_latch

    task t_stat_write;
        frame(8, 40'h06);
        frame(16, 40'h01ff);
        stat(8'h03, -1);
        frame(16, 40'h0100);
        #8000;
        stat(8'h8c, -1);
        stat(8'h8c, 12);
    endtask : t_stat_write

    task t_protect;
        @(negedge clk);
        wp_n = 1'b0;
        #1000;
        frame(8, 40'h06);
        frame(16, 40'h0100);
        #8000;
        stat(8'h8e, -1);
        @(negedge clk);
        wp_n = 1'b1;
        #1000;
        frame(17, 40'h00200);
        #8000;
        stat(8'h8e, -1);
        frame(16, 40'h0100);
        #8000;
        stat(8'h00, -1);
    endtask : t_protect

    task t_memory;
        frame(8, 40'h06);
        frame(32, 40'h02_0000_a5);
        stat(8'h03, -1);
        #8000;
        stat(8'h00, -1);
        frame(32, 40'h03_e000_00);
        chk("aliased byte", {8'h00, q[7:0]}, 16'h00a5);
        frame(40, 40'h03_1fff_0000);
        chk("wrapped read", q[15:0], 16'hffa5);
    endtask : t_memory

    task t_bad_op;
        frame(16, 40'h0700);
        chk("unknown op", {8'h00, q[7:0]}, 16'h00zz);
        stat(8'h00, -1);
    endtask : t_bad_op

    initial begin
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (5) @(negedge clk);
        t_fresh;
        t_latch;
        t_stat_write;
        t_protect;
        t_memory;
        t_bad_op;
        end_sim;
    end

    initial begin
        #2000000;
        bad_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        end_sim;
    end
endmodule : secs_top_tb

bind secs_top secs_top_assertions i_secs_top_assertions (.clk(clk), .rstn(rstn),
    .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_hold_n(spi_hold_n),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .wp_n(wp_n));
